// ### rtl/ldr_pkg.sv
// Notes on behaviour
// - Status bit 5 reads 1 when reference input 2 feeds loop one.
// - Status bits 4 and 3 flag reference input 1 or 0 selected for loop one.
// - Status bits 1 and 0 follow signal loss on reference input 1 and 0.
// - Tuning DAC bits 9:8 read at input_select_los_status bits 7:6, bits 7:0 at tuning_dac_low_readback.
// - Tuning DAC readback is 512 after reset; changes only once loop one locks.
// - Register holdover_state_readback bit 4 reads 1 while in holdover.
// - A nonzero write-protect key blocks every write except to 0x555.
// - The write-protect key never reads back its contents.
// - Lock event only after lock-count in-window phase detector cycles.
// - An out-of-window cycle clears the lock cycle counter to zero.
// - A lock event raises that loop's digital lock indicator.
// - With exit mode 1, holdover ends on the holdover-exit lock event.
// - Each loop has own window and count; holdover exit uses loop-one window.
package ldr_pkg;
  localparam int ADDR_W = 15;
  localparam int WND_W = 8;
  localparam int CNT_W = 14;
  localparam int DAC_W = 10;

  localparam logic [ADDR_W-1:0] ADDR_IN_STATUS = 15'h0184;
  localparam logic [ADDR_W-1:0] ADDR_DAC_LOW = 15'h0185;
  localparam logic [ADDR_W-1:0] ADDR_HOLDOVER = 15'h0188;
  localparam logic [ADDR_W-1:0] ADDR_WP_KEY = 15'h0555;

  localparam int BIT_IN2_SEL = 5;
  localparam int BIT_IN1_SEL = 4;
  localparam int BIT_IN0_SEL = 3;
  localparam int BIT_IN1_LOS = 1;
  localparam int BIT_IN0_LOS = 0;
  localparam int BIT_HOLDOVER = 4;

  localparam logic [DAC_W-1:0] DAC_RESET = 10'h200;
  localparam logic [7:0] WP_KEY_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  localparam logic [1:0] SEL_IN0 = 2'h0;
  localparam logic [1:0] SEL_IN1 = 2'h1;
  localparam logic [1:0] SEL_IN2 = 2'h2;
endpackage

// ### rtl/ldr_lock_window.sv
`timescale 1ns/10ps
module ldr_lock_window
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ref_lvl,
  input wire logic fb_lvl,
  input wire logic [ldr_pkg::WND_W-1:0] window_size,
  input wire logic [ldr_pkg::CNT_W-1:0] lock_count,
  output logic lock_ff,
  output logic event_ff
);
  logic ref_q_ff;
  logic fb_q_ff;
  logic armed_ff;
  logic [ldr_pkg::WND_W:0] timer_ff;
  logic [ldr_pkg::CNT_W-1:0] count_ff;
  logic ref_rise;
  logic fb_rise;
  logic good;
  logic miss;
  logic reached;

  assign ref_rise = ref_lvl & ~ref_q_ff;
  assign fb_rise = fb_lvl & ~fb_q_ff;
  // A pair closes on the next rising edge of either divider output
  assign good = (ref_rise & fb_rise & ~armed_ff) | (armed_ff & (ref_rise | fb_rise)
    & (timer_ff <= {1'b0, window_size}));
  assign miss = (armed_ff & (ref_rise | fb_rise) & (timer_ff > {1'b0, window_size}))
    | (armed_ff & ~ref_rise & ~fb_rise & (timer_ff > {1'b0, window_size}));
  assign reached = (count_ff + ldr_pkg::CNT_W'(1)) >= lock_count;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ref_q_ff <= 1'b0;
      fb_q_ff <= 1'b0;
    end
    else
    begin
      ref_q_ff <= ref_lvl;
      fb_q_ff <= fb_lvl;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      armed_ff <= 1'b0;
      timer_ff <= '0;
    end
    else if (good || miss)
      armed_ff <= 1'b0;
    else if (!armed_ff && (ref_rise || fb_rise))
    begin
      armed_ff <= 1'b1;
      timer_ff <= '0;
    end
    else if (armed_ff)
      timer_ff <= timer_ff + (ldr_pkg::WND_W+1)'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      count_ff <= '0;
    else if (miss)
      count_ff <= '0;
    else if (good && !reached)
      count_ff <= count_ff + ldr_pkg::CNT_W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lock_ff <= 1'b0;
      event_ff <= 1'b0;
    end
    else
    begin
      event_ff <= good && reached && !lock_ff;
      if (miss)
        lock_ff <= 1'b0;
      else if (good && reached)
        lock_ff <= 1'b1;
    end
  end

  a_miss_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    miss |=> count_ff == '0 && !lock_ff)
    else $error("lock counter not cleared after window miss");
  a_lock_after_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(lock_ff) |-> $past(good) && $past(count_ff) + ldr_pkg::CNT_W'(1) >= $past(lock_count))
    else $error("lock raised before lock count reached");
  a_event_raises: assert property (@(posedge clk_sys) disable iff (!rst_n)
    event_ff |-> lock_ff && !$past(lock_ff))
    else $error("lock event without indicator rising");
  c_lock_event: cover property (@(posedge clk_sys) disable iff (!rst_n) event_ff);
endmodule

// ### rtl/ldr_top.sv
`timescale 1ns/10ps
module ldr_top
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ldr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  output logic fwd_wr_ff,
  output logic [ldr_pkg::ADDR_W-1:0] fwd_addr_ff,
  output logic [7:0] fwd_wdata_ff,
  output logic wr_blocked_ff,
  input wire logic loop1_ref_divider_out,
  input wire logic loop1_feedback_divider_out,
  input wire logic loop2_ref_divider_out,
  input wire logic loop2_feedback_divider_out,
  input wire logic input0_signal_loss_detect,
  input wire logic input1_signal_loss_detect,
  input wire logic [1:0] input_select,
  input wire logic [ldr_pkg::DAC_W-1:0] tuning_dac_value,
  input wire logic [ldr_pkg::WND_W-1:0] loop1_window_size,
  input wire logic [ldr_pkg::WND_W-1:0] loop2_window_size,
  input wire logic [ldr_pkg::CNT_W-1:0] loop1_lock_count,
  input wire logic [ldr_pkg::CNT_W-1:0] loop2_lock_count,
  input wire logic [ldr_pkg::CNT_W-1:0] holdover_exit_count,
  input wire logic holdover_exit_mode,
  input wire logic holdover_enter,
  output logic loop1_digital_lock_indicator_ff,
  output logic loop2_digital_lock_indicator_ff,
  output logic holdover_active_flag_ff
);
  // Divider outputs and loss detectors come from other clock domains
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [7:0] wp_key_ff;
  logic [ldr_pkg::DAC_W-1:0] dac_ff;
  logic dac_live_ff;
  logic loop1_event;
  logic loop2_event;
  logic hx_event;
  logic wr_locked;
  logic wr_status;
  logic [7:0] status_byte;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= {input1_signal_loss_detect, input0_signal_loss_detect, loop2_feedback_divider_out,
        loop2_ref_divider_out, loop1_feedback_divider_out, loop1_ref_divider_out};
      sync2_ff <= sync1_ff;
    end
  end

  // Each event uses its own count; the holdover exit shares loop one's window
  ldr_lock_window u_loop1
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ref_lvl(sync2_ff[0]),
    .fb_lvl(sync2_ff[1]),
    .window_size(loop1_window_size),
    .lock_count(loop1_lock_count),
    .lock_ff(loop1_digital_lock_indicator_ff),
    .event_ff(loop1_event)
  );

  ldr_lock_window u_loop2
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ref_lvl(sync2_ff[2]),
    .fb_lvl(sync2_ff[3]),
    .window_size(loop2_window_size),
    .lock_count(loop2_lock_count),
    .lock_ff(loop2_digital_lock_indicator_ff),
    .event_ff(loop2_event)
  );

  ldr_lock_window u_hold_exit
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ref_lvl(sync2_ff[0]),
    .fb_lvl(sync2_ff[1]),
    .window_size(loop1_window_size),
    .lock_count(holdover_exit_count),
    .lock_ff(),
    .event_ff(hx_event)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      holdover_active_flag_ff <= 1'b0;
    else if (holdover_enter)
      holdover_active_flag_ff <= 1'b1;
    else if (hx_event && holdover_exit_mode)
      holdover_active_flag_ff <= 1'b0;
  end

  // DAC stays at midscale until loop one has locked once
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      dac_live_ff <= 1'b0;
      dac_ff <= ldr_pkg::DAC_RESET;
    end
    else
    begin
      if (loop1_event)
        dac_live_ff <= 1'b1;
      if (dac_live_ff)
        dac_ff <= tuning_dac_value;
    end
  end

  assign wr_locked = wp_key_ff != ldr_pkg::WP_KEY_RESET;
  assign wr_status = reg_addr == ldr_pkg::ADDR_IN_STATUS || reg_addr == ldr_pkg::ADDR_DAC_LOW
    || reg_addr == ldr_pkg::ADDR_HOLDOVER;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      wp_key_ff <= ldr_pkg::WP_KEY_RESET;
    else if (reg_wr && reg_addr == ldr_pkg::ADDR_WP_KEY)
      wp_key_ff <= reg_wdata;
  end

  // Status and key writes never raise fwd_wr_ff, but fwd_addr_ff and fwd_wdata_ff still load them
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fwd_wr_ff <= 1'b0;
      fwd_addr_ff <= '0;
      fwd_wdata_ff <= 8'h00;
      wr_blocked_ff <= 1'b0;
    end
    else
    begin
      fwd_wr_ff <= reg_wr && !wr_locked && !wr_status && reg_addr != ldr_pkg::ADDR_WP_KEY;
      wr_blocked_ff <= reg_wr && wr_locked && reg_addr != ldr_pkg::ADDR_WP_KEY;
      if (reg_wr)
      begin
        fwd_addr_ff <= reg_addr;
        fwd_wdata_ff <= reg_wdata;
      end
    end
  end

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[7:6] = dac_ff[9:8];
    status_byte[ldr_pkg::BIT_IN2_SEL] = input_select == ldr_pkg::SEL_IN2;
    status_byte[ldr_pkg::BIT_IN1_SEL] = input_select == ldr_pkg::SEL_IN1;
    status_byte[ldr_pkg::BIT_IN0_SEL] = input_select == ldr_pkg::SEL_IN0;
    status_byte[ldr_pkg::BIT_IN1_LOS] = sync2_ff[5];
    status_byte[ldr_pkg::BIT_IN0_LOS] = sync2_ff[4];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      reg_rdata_ff <= ldr_pkg::RDATA_RESET;
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_rvalid_ff <= reg_rd;
      if (!reg_rd)
        reg_rdata_ff <= ldr_pkg::RDATA_RESET;
      else if (reg_addr == ldr_pkg::ADDR_IN_STATUS)
        reg_rdata_ff <= status_byte;
      else if (reg_addr == ldr_pkg::ADDR_DAC_LOW)
        reg_rdata_ff <= dac_ff[7:0];
      else if (reg_addr == ldr_pkg::ADDR_HOLDOVER)
        reg_rdata_ff <= {3'h0, holdover_active_flag_ff, 4'h0};
      else
        reg_rdata_ff <= ldr_pkg::RDATA_RESET; // key and unmapped read zero
    end
  end

  a_in2_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == ldr_pkg::ADDR_IN_STATUS |=> reg_rdata_ff[5] == ($past(input_select) == 2'h2))
    else $error("input 2 select bit wrong");
  a_in10_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == ldr_pkg::ADDR_IN_STATUS |=>
    reg_rdata_ff[4:3] == {$past(input_select) == 2'h1, $past(input_select) == 2'h0})
    else $error("input 1/0 select bits wrong");
  a_los_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == ldr_pkg::ADDR_IN_STATUS |=> reg_rdata_ff[1:0] == $past(sync2_ff[5:4]))
    else $error("loss bits wrong");
  a_dac_split: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == ldr_pkg::ADDR_DAC_LOW |=> reg_rdata_ff == $past(dac_ff[7:0]))
    else $error("dac low byte wrong");
  a_dac_reset: assert property (@(posedge clk_sys)
    !rst_n |=> dac_ff == 10'h200 && !dac_live_ff)
    else $error("dac readback not 512 after reset");
  a_dac_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !dac_live_ff |=> $stable(dac_ff))
    else $error("dac changed before first lock");
  a_holdover_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == ldr_pkg::ADDR_HOLDOVER |=> reg_rdata_ff == {3'h0, $past(holdover_active_flag_ff), 4'h0})
    else $error("holdover bit wrong");
  a_write_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && wp_key_ff != 8'h00 && reg_addr != ldr_pkg::ADDR_WP_KEY |=> !fwd_wr_ff && wr_blocked_ff)
    else $error("write passed while locked");
  a_key_hidden: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == ldr_pkg::ADDR_WP_KEY |=> reg_rvalid_ff && reg_rdata_ff == 8'h00)
    else $error("key read back");
  a_holdover_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hx_event && holdover_exit_mode && !holdover_enter |=> !holdover_active_flag_ff)
    else $error("holdover not left on exit event");
  a_status_ro: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && wr_status |=> !fwd_wr_ff)
    else $error("status write forwarded");

  c_loop1_lock: cover property (@(posedge clk_sys) disable iff (!rst_n) loop1_event);
  c_loop2_lock: cover property (@(posedge clk_sys) disable iff (!rst_n) loop2_event);
  c_hold_exit: cover property (@(posedge clk_sys) disable iff (!rst_n)
    holdover_active_flag_ff ##1 !holdover_active_flag_ff);
  c_blocked: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_blocked_ff);
endmodule

// ### verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ldr_pkg::ADDR_W-1:0] reg_addr = 15'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_ff, fwd_wdata_ff;
  logic reg_rvalid_ff, fwd_wr_ff, wr_blocked_ff;
  logic [ldr_pkg::ADDR_W-1:0] fwd_addr_ff;
  logic loop1_ref_divider_out = 1'b0, loop1_feedback_divider_out = 1'b0;
  logic loop2_ref_divider_out = 1'b0, loop2_feedback_divider_out = 1'b0;
  logic input0_signal_loss_detect = 1'b0, input1_signal_loss_detect = 1'b0;
  logic [1:0] input_select = 2'h0;
  logic [ldr_pkg::DAC_W-1:0] tuning_dac_value = 10'h000;
  logic [ldr_pkg::WND_W-1:0] loop1_window_size = 8'h02, loop2_window_size = 8'h03;
  logic [ldr_pkg::CNT_W-1:0] loop1_lock_count = 14'h0003, loop2_lock_count = 14'h0004;
  logic [ldr_pkg::CNT_W-1:0] holdover_exit_count = 14'h0005;
  logic holdover_exit_mode = 1'b0, holdover_enter = 1'b0;
  logic loop1_digital_lock_indicator_ff, loop2_digital_lock_indicator_ff, holdover_active_flag_ff;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'hE482B25C;
  logic [31:0] r;
  logic [9:0] dv;
  logic hx;

  ldr_top i_ldr_top
  (
    .clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff, .reg_rvalid_ff,
    .fwd_wr_ff, .fwd_addr_ff, .fwd_wdata_ff, .wr_blocked_ff, .loop1_ref_divider_out,
    .loop1_feedback_divider_out, .loop2_ref_divider_out, .loop2_feedback_divider_out,
    .input0_signal_loss_detect, .input1_signal_loss_detect, .input_select, .tuning_dac_value,
    .loop1_window_size, .loop2_window_size, .loop1_lock_count, .loop2_lock_count,
    .holdover_exit_count, .holdover_exit_mode, .holdover_enter, .loop1_digital_lock_indicator_ff,
    .loop2_digital_lock_indicator_ff, .holdover_active_flag_ff
  );

  always #20 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] st(input logic [9:0] d);
    return {d[9:8], input_select == 2'h2, input_select == 2'h1, input_select == 2'h0, 1'b0,
      input1_signal_loss_detect, input0_signal_loss_detect};
  endfunction

  task automatic print_verdict();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid_ff, 16'h0001);
    chk(reg_rdata_ff, e);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic ef, input logic eb);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
    chk(fwd_wr_ff, ef);
    chk(wr_blocked_ff, eb);
  endtask

  // Both loops see the same edges; only their window and count differ
  task automatic pd_pair(input int gap);
    @(posedge clk_sys);
    loop1_ref_divider_out <= 1'b1;
    loop2_ref_divider_out <= 1'b1;
    repeat (gap) @(posedge clk_sys);
    loop1_feedback_divider_out <= 1'b1;
    loop2_feedback_divider_out <= 1'b1;
    repeat (3) @(posedge clk_sys);
    {loop1_ref_divider_out, loop2_ref_divider_out} <= 2'h0;
    {loop1_feedback_divider_out, loop2_feedback_divider_out} <= 2'h0;
    // Room for the synchronisers and a window timeout
    repeat (8) @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      @(posedge clk_sys);
      input_select <= i[1:0];
      {input1_signal_loss_detect, input0_signal_loss_detect} <= r[1:0]; // Buffer type 1 assumed upstream
      tuning_dac_value <= r[11:2];
      repeat (4) @(posedge clk_sys);
      rd(ldr_pkg::ADDR_IN_STATUS, st(ldr_pkg::DAC_RESET));
      rd(ldr_pkg::ADDR_DAC_LOW, 8'h00);
    end
    $display("test status done");
    wr(ldr_pkg::ADDR_IN_STATUS, 8'hFF, 1'b0, 1'b0);
    wr(ldr_pkg::ADDR_DAC_LOW, 8'hFF, 1'b0, 1'b0);
    wr(ldr_pkg::ADDR_HOLDOVER, 8'hFF, 1'b0, 1'b0);
    rd(ldr_pkg::ADDR_DAC_LOW, 8'h00);
    rd(ldr_pkg::ADDR_HOLDOVER, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      r = rnd();
      wr(ldr_pkg::ADDR_WP_KEY, (k == 0) ? 8'h01 : (k == 1) ? 8'hFF : (r[7:0] | 8'h01), 1'b0, 1'b0);
      // Top address bit set, so never the key register
      wr({1'b1, r[21:8]}, r[31:24], 1'b0, 1'b1);
      rd(ldr_pkg::ADDR_WP_KEY, 8'h00);
    end
    wr(ldr_pkg::ADDR_WP_KEY, 8'h00, 1'b0, 1'b0);
    wr(15'h0010, 8'h5A, 1'b1, 1'b0);
    chk(fwd_addr_ff, 16'h0010);
    chk(fwd_wdata_ff, 16'h005A);
    $display("test key done");
    // Each pass starts with a miss and must relock from zero; pass 0 keeps holdover (mode 0), pass 1 leaves it
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk_sys);
      holdover_exit_mode <= p[0];
      holdover_enter <= 1'b1;
      @(posedge clk_sys);
      holdover_enter <= 1'b0;
      pd_pair(6);
      chk(loop1_digital_lock_indicator_ff, 16'h0000);
      chk(loop2_digital_lock_indicator_ff, 16'h0000);
      for (int n = 1; n < 6; n++)
      begin
        pd_pair((n == 2) ? 0 : 1);
        hx = (p == 0) || (n < 5);
        chk(loop1_digital_lock_indicator_ff, n >= 3);
        chk(loop2_digital_lock_indicator_ff, n >= 4);
        chk(holdover_active_flag_ff, hx);
      end
      rd(ldr_pkg::ADDR_HOLDOVER, {3'h0, hx, 4'h0});
    end
    $display("test lock done");
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      dv = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : r[9:0];
      @(posedge clk_sys);
      tuning_dac_value <= dv;
      rd(ldr_pkg::ADDR_IN_STATUS, st(dv));
      rd(ldr_pkg::ADDR_DAC_LOW, dv[7:0]);
    end
    $display("test dac done");
    print_verdict();
  end
endmodule
